// >>> hdl/spss_cfg.svh
// offsets, field positions, reset values and timing counts of the present-state block
`ifndef SPSS_CFG_SVH
`define SPSS_CFG_SVH
`define SPSS_OFF_PRESENT 8'h08
`define SPSS_OFF_FORCE 8'h0C
`define SPSS_RESET_WORD 32'h3000_0000
`define SPSS_SUPPLY_DEFAULT 4'h3
`define SPSS_B_SUP_HI 31
`define SPSS_B_SUP_LO 28
`define SPSS_B_ZV 27
`define SPSS_B_RSVD_HI 26
`define SPSS_B_RSVD_LO 14
`define SPSS_B_RETEST 14
`define SPSS_B_ACC_HI 13
`define SPSS_B_ACC_LO 10
`define SPSS_B_BADREQ 9
`define SPSS_B_LOSS 8
`define SPSS_B_UNREC 7
`define SPSS_B_READY 6
`define SPSS_B_TYPE32 5
`define SPSS_B_TYPE16 4
`define SPSS_B_POWER 3
`define SPSS_B_DET_B 2
`define SPSS_B_DET_A 1
`define SPSS_B_STS 0
`define SPSS_SYNC_STAGES 2
`define SPSS_PIN_COUNT 4
`endif

// >>> hdl/spss_pkg.sv
// types shared by the present-state block
package spss_pkg;
   // one register word
   typedef logic [31:0] spss_word_t;
   // supply capability nibble, yy code first, 5 volt code last
   typedef struct packed {
      logic yy;
      logic xx;
      logic v33;
      logic v50;
   } spss_supply_s;
endpackage

// >>> hdl/spss_present_state.sv
// socket present-state status register with its live pin and card fields
// Overview of operation
// (RULE1) force-event writes show in status fields
// (RULE2) supply and type fields change per insertion
// (RULE3) detect bits frozen during card identification
// (RULE4) word read-only, resets to 3000_00XX
// (RULE5) Y.Y and X.X socket supply read 0
// (RULE6) 3.3 and 5 volt socket supply read 1
// (RULE7) one bit reports zoomed video support
// (RULE8) bits 26 to 14 read zero
// (RULE9) four card supply bits, 13 to 10
// (RULE10) flag invalid supply request, default 0
// (RULE11) flag possible data loss on removal
// (RULE12) unrecognised card flag, held until valid card
// (RULE13) bit 6 mirrors ready/irq pin level
// (RULE14) card type bits set at interrogation only
// (RULE15) bit 3 shows socket power state
// (RULE16) bits 2,1 mirror both detect pins
// (RULE17) bit 0 mirrors status-change pin level
// (RULE18) status event: rise for 32-bit, both for 16-bit
// (RULE19) retest command re-interrogates and refreshes status
// (RULE20) host reaches register at window offset 08h
// (RULE21) pin levels synchronised before being shown
`include "spss_cfg.svh"
module spss_present_state #(
   parameter int ACC_W = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [7:0] win_addr,
   input wire logic win_rd,
   input wire logic win_wr,
   input wire logic [31:0] win_wdata,
   input wire logic ccd1_n_pin,
   input wire logic ccd2_n_pin,
   input wire logic cstschg_pin,
   input wire logic ready_irq_pin,
   input wire logic zv_capable_in,
   input wire logic interrog_busy,
   input wire logic interrog_done,
   input wire logic [ACC_W-1:0] id_accepts,
   input wire logic id_is_32bit,
   input wire logic id_is_16bit,
   input wire logic id_unrecognised,
   input wire logic bad_supply_req,
   input wire logic loss_on_removal,
   input wire logic power_req,
   input wire logic power_on,
   output logic [31:0] win_rdata,
   output logic win_rvalid,
   output logic retest_req,
   output logic status_change_pin_level_event
);
   // window decode
   logic rd_present; // read of the status word
   logic wr_force; // write of the force-event word
   // held fields
   spss_pkg::spss_supply_s supply_reg; // socket supply capabilities
   logic zoomed_video_capable; // zoomed video support
   logic [ACC_W-1:0] accepts_reg; // card supply acceptance
   logic invalid_supply_request; // bad supply flag
   logic removal_loss_flag; // data-loss flag
   logic unrecognised_card_flag; // unknown card flag
   logic card_is_32bit_type; // cardbus type
   logic card_is_16bit_type; // 16-bit type
   logic socket_power_state; // powered up
   // live pin mirrors
   logic card_ready_irq_level;
   logic detect_pin_b_level;
   logic detect_pin_a_level;
   logic status_change_pin_level;
   // assembled word
   spss_pkg::spss_word_t status_word;
   logic sts_rise; // status pin rising
   logic sts_change; // status pin any edge

   assign rd_present = ce && win_rd && (win_addr == `SPSS_OFF_PRESENT);
   assign wr_force = ce && win_wr && (win_addr == `SPSS_OFF_FORCE);

   // pin synchroniser, pins in fixed order: ready, det b, det a, status
   spss_sync_if #(.W(`SPSS_PIN_COUNT)) pin_if ();
   assign pin_if.clk = core_clk;
   assign pin_if.rst = sys_rst;
   assign pin_if.ce = ce;
   assign pin_if.raw = {ready_irq_pin, ccd2_n_pin, ccd1_n_pin, cstschg_pin};

   // (RULE21) settled pin levels
   spss_sync #(.W(`SPSS_PIN_COUNT)) u_pin_sync (
      .sif(pin_if.sync_end)
   );

   // socket supply capabilities
   // these are fixed by the socket; a force write may fake them for tests
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         // (RULE6) 3.3 and 5 volt supported
         supply_reg <= `SPSS_SUPPLY_DEFAULT;
      end else if (ce) begin
         if (wr_force) begin
            // (RULE1) forced capability values
            supply_reg <= win_wdata[`SPSS_B_SUP_HI:`SPSS_B_SUP_LO];
         end else if (interrog_done) begin
            // (RULE5) yy and xx unsupported, restored per insertion
            supply_reg <= `SPSS_SUPPLY_DEFAULT;
         end
      end
   end

   // zoomed video support bit
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         zoomed_video_capable <= 1'b0;
      end else if (ce) begin
         if (wr_force) begin
            // (RULE7) forced support level
            zoomed_video_capable <= win_wdata[`SPSS_B_ZV];
         end else if (interrog_done) begin
            // (RULE7) sampled at insertion, no async capture
            zoomed_video_capable <= zv_capable_in;
         end
      end
   end

   // card supply acceptance and type, one load per recognised insertion
   // (RULE2) held between insertions
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         accepts_reg <= '0;
         card_is_32bit_type <= 1'b0;
         card_is_16bit_type <= 1'b0;
      end else if (ce) begin
         if (wr_force) begin
            // (RULE1) forced card fields
            accepts_reg <= win_wdata[`SPSS_B_ACC_HI:`SPSS_B_ACC_LO];
            card_is_32bit_type <= win_wdata[`SPSS_B_TYPE32];
            card_is_16bit_type <= win_wdata[`SPSS_B_TYPE16];
         end else if (interrog_done && !id_unrecognised) begin
            // (RULE9) acceptance of yy, xx, 3.3, 5 volt
            accepts_reg <= id_accepts;
            // (RULE14) type only at a new interrogation
            card_is_32bit_type <= id_is_32bit;
            card_is_16bit_type <= id_is_16bit;
         end
      end
   end

   // invalid supply request flag
   // a hardware set in the clearing cycle wins
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         invalid_supply_request <= 1'b0;
      end else if (ce) begin
         if (bad_supply_req) begin
            // (RULE10) host asked for a bad voltage
            invalid_supply_request <= 1'b1;
         end else if (wr_force) begin
            invalid_supply_request <= win_wdata[`SPSS_B_BADREQ];
         end else if (power_req) begin
            // a valid request ends the fault
            invalid_supply_request <= 1'b0;
         end
      end
   end

   // data-loss flag
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         removal_loss_flag <= 1'b0;
      end else if (ce) begin
         if (loss_on_removal) begin
            // (RULE11) unfinished cycle or posted write lost
            removal_loss_flag <= 1'b1;
         end else if (wr_force) begin
            removal_loss_flag <= win_wdata[`SPSS_B_LOSS];
         end else if (interrog_done) begin
            // next insertion starts clean
            removal_loss_flag <= 1'b0;
         end
      end
   end

   // unrecognised card flag
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         unrecognised_card_flag <= 1'b0;
      end else if (ce) begin
         if (interrog_done) begin
            // (RULE12) a valid card, or a force write with bit 7 low, clears it
            unrecognised_card_flag <= id_unrecognised;
         end else if (wr_force) begin
            unrecognised_card_flag <= win_wdata[`SPSS_B_UNREC];
         end
      end
   end

   // socket power state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         socket_power_state <= 1'b0;
      end else if (ce && power_req && !bad_supply_req) begin
         // (RULE15) follows each accepted power request
         socket_power_state <= power_on;
      end
   end

   // live pin mirrors
   // detect pins double as identification lines, so they freeze meanwhile
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         card_ready_irq_level <= 1'b0;
         detect_pin_b_level <= 1'b0;
         detect_pin_a_level <= 1'b0;
         status_change_pin_level <= 1'b0;
      end else if (ce) begin
         // (RULE13) ready/irq level
         card_ready_irq_level <= pin_if.synced[3];
         // (RULE17) status-change level
         status_change_pin_level <= pin_if.synced[0];
         // (RULE3) frozen during identification
         if (!interrog_busy) begin
            // (RULE16) detect pin levels
            detect_pin_b_level <= pin_if.synced[2];
            detect_pin_a_level <= pin_if.synced[1];
         end
      end
   end

   // edges of the settled status-change level
   assign sts_rise = pin_if.synced[0] && !status_change_pin_level;
   assign sts_change = pin_if.synced[0] != status_change_pin_level;

   // status event toward the event register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_change_pin_level_event <= 1'b0;
      end else if (ce) begin
         // (RULE18) edge choice by card type, force bit also fires
         status_change_pin_level_event <= (card_is_32bit_type && sts_rise) ||
                          (card_is_16bit_type && sts_change) ||
                          (wr_force && win_wdata[`SPSS_B_STS]);
      end
   end

   // retest command toward the interrogation logic
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         retest_req <= 1'b0;
      end else if (ce) begin
         // (RULE19) one-cycle request per written command
         retest_req <= wr_force && win_wdata[`SPSS_B_RETEST];
      end
   end

   // status word assembly
   always_comb begin
      status_word = '0;
      // (RULE8) reserved span stays zero
      status_word[`SPSS_B_SUP_HI:`SPSS_B_SUP_LO] = supply_reg;
      status_word[`SPSS_B_ZV] = zoomed_video_capable;
      status_word[`SPSS_B_ACC_HI:`SPSS_B_ACC_LO] = accepts_reg;
      status_word[`SPSS_B_BADREQ] = invalid_supply_request;
      status_word[`SPSS_B_LOSS] = removal_loss_flag;
      status_word[`SPSS_B_UNREC] = unrecognised_card_flag;
      status_word[`SPSS_B_READY] = card_ready_irq_level;
      status_word[`SPSS_B_TYPE32] = card_is_32bit_type;
      status_word[`SPSS_B_TYPE16] = card_is_16bit_type;
      status_word[`SPSS_B_POWER] = socket_power_state;
      status_word[`SPSS_B_DET_B] = detect_pin_b_level;
      status_word[`SPSS_B_DET_A] = detect_pin_a_level;
      status_word[`SPSS_B_STS] = status_change_pin_level;
   end

   // window read port; writes at the status offset fall on the floor
   // (RULE4) no write path here
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         win_rdata <= '0;
         win_rvalid <= 1'b0;
      end else if (ce) begin
         win_rvalid <= win_rd;
         if (rd_present) begin
            // (RULE20) status at window offset 08h
            win_rdata <= status_word;
         end else if (win_rd) begin
            // other offsets belong elsewhere, read as zero
            win_rdata <= '0;
         end
      end
   end

   // checks
   property p_rsvd_zero;
      @(posedge core_clk) disable iff (sys_rst)
      rd_present |=> win_rvalid && (win_rdata[`SPSS_B_RSVD_HI:`SPSS_B_RSVD_LO] == '0);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero"); // RULE8

   property p_reset_word;
      @(posedge core_clk)
      sys_rst |=> (status_word[31:8] == `SPSS_RESET_WORD >> 8);
   endproperty
   a_reset_word: assert property (p_reset_word) else $error("bad reset word"); // RULE4

   property p_supply_reload;
      @(posedge core_clk) disable iff (sys_rst)
      ce && interrog_done && !wr_force |=> supply_reg == `SPSS_SUPPLY_DEFAULT;
   endproperty
   a_supply_reload: assert property (p_supply_reload) else $error("supply bits wrong"); // RULE6

   property p_detect_frozen;
      @(posedge core_clk) disable iff (sys_rst)
      interrog_busy |=> $stable(detect_pin_a_level) && $stable(detect_pin_b_level);
   endproperty
   a_detect_frozen: assert property (p_detect_frozen) else $error("detect moved while busy"); // RULE3

   property p_bad_req;
      @(posedge core_clk) disable iff (sys_rst)
      ce && bad_supply_req |=> invalid_supply_request;
   endproperty
   a_bad_req: assert property (p_bad_req) else $error("bad request not flagged"); // RULE10

   property p_loss;
      @(posedge core_clk) disable iff (sys_rst)
      ce && loss_on_removal |=> removal_loss_flag;
   endproperty
   a_loss: assert property (p_loss) else $error("loss not flagged"); // RULE11

   property p_unrec;
      @(posedge core_clk) disable iff (sys_rst)
      ce && interrog_done |=> unrecognised_card_flag == $past(id_unrecognised);
   endproperty
   a_unrec: assert property (p_unrec) else $error("unrecognised flag wrong"); // RULE12

   property p_type;
      @(posedge core_clk) disable iff (sys_rst)
      ce && interrog_done && !id_unrecognised && !wr_force
      |=> {card_is_32bit_type, card_is_16bit_type} == $past({id_is_32bit, id_is_16bit});
   endproperty
   a_type: assert property (p_type) else $error("card type not loaded"); // RULE14

   property p_power;
      @(posedge core_clk) disable iff (sys_rst)
      ce && power_req && !bad_supply_req |=> socket_power_state == $past(power_on);
   endproperty
   a_power: assert property (p_power) else $error("power state wrong"); // RULE15

   property p_sts_level;
      @(posedge core_clk) disable iff (sys_rst)
      (ce && cstschg_pin) [*4] |-> status_change_pin_level;
   endproperty
   a_sts_level: assert property (p_sts_level) else $error("status pin not mirrored"); // RULE17

   property p_retest;
      @(posedge core_clk) disable iff (sys_rst)
      wr_force && win_wdata[`SPSS_B_RETEST] |=> retest_req ##1 (!retest_req || $past(wr_force) || !$past(ce));
   endproperty
   a_retest: assert property (p_retest) else $error("retest not issued"); // RULE19
endmodule

// >>> hdl/spss_sync.sv
// two-stage synchroniser for the socket pin levels
`include "spss_cfg.svh"
module spss_sync #(
   parameter int W = 4
) (
   spss_sync_if.sync_end sif
);
   // first stage, read only by the second
   logic [W-1:0] meta_reg;
   // second stage, the settled level
   logic [W-1:0] settle_reg;

   // pins carry no timing relation to core_clk, so settle over two flops
   always_ff @(posedge sif.clk) begin
      if (sif.rst) begin
         meta_reg <= '0;
         settle_reg <= '0;
      end else if (sif.ce) begin
         meta_reg <= sif.raw;
         settle_reg <= meta_reg;
      end
   end

   assign sif.synced = settle_reg;
endmodule

// >>> hdl/spss_sync_if.sv
// carrier between the status block and its pin synchroniser
interface spss_sync_if #(parameter int W = 4);
   logic clk; // sampling clock
   logic rst; // synchronous reset
   logic ce; // freezes the stages while low
   logic [W-1:0] raw; // pin levels, asynchronous
   logic [W-1:0] synced; // levels after the last stage
   modport sync_end (input clk, input rst, input ce, input raw, output synced);
   modport user_end (output clk, output rst, output ce, output raw, input synced);
endinterface

// >>> tb/spss_card_model.sv
// behavioural card sitting in the socket, driving the socket pins
module spss_card_model (
   input wire logic present,
   input wire logic sts_lvl,
   input wire logic rdy_lvl,
   output logic ccd1_n,
   output logic ccd2_n,
   output logic cstschg,
   output logic ready_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // detect pins pulled high with no card, pulled low by a seated card
   assign ccd1_n = ~present;
   assign ccd2_n = ~present;
   // released pins fall to their pull-down, not to the last level
   assign cstschg = present & sts_lvl;
   assign ready_irq = present & rdy_lvl;
endmodule

// >>> tb/tb.sv
// self-checking bench for the socket present-state block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // one interrogation result beside the word it should give
   typedef struct {logic [3:0] acc; logic t32; logic t16; logic unr; logic zv; logic [31:0] exp;} spss_row_s;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic ce = 1'h1;
   logic [7:0] win_addr = 8'h00;
   logic win_rd = 1'h0;
   logic win_wr = 1'h0;
   logic [31:0] win_wdata = 32'h0000_0000;
   logic ccd1_n, ccd2_n, sts_pin, rdy_pin; // socket pins from the card
   logic zv = 1'h0, busy = 1'h0, done = 1'h0; // interrogation side
   logic [3:0] acc = 4'h0;
   logic t32 = 1'h0, t16 = 1'h0, unr = 1'h0, bad = 1'h0, loss = 1'h0, preq = 1'h0, pon = 1'h0;
   logic present = 1'h0, sts = 1'h0, rdy = 1'h0; // card model controls
   logic [31:0] win_rdata, rd_w;
   logic win_rvalid, retest_req, status_change_pin_level_event;
   int err_count = 0;
   int comparisons = 0;
   int ev_cnt = 0; // status-pin events seen so far
   int base;
   // ordinary insertions; unrecognised row must leave accepts and type alone
   spss_row_s rows [4] = '{
      '{4'h3, 1'h1, 1'h0, 1'h0, 1'h1, 32'h3800_0C60},
      '{4'h1, 1'h0, 1'h1, 1'h0, 1'h0, 32'h3000_0450},
      '{4'hF, 1'h1, 1'h0, 1'h1, 1'h0, 32'h3000_04D0},
      '{4'h2, 1'h1, 1'h0, 1'h0, 1'h1, 32'h3800_0860}};

   spss_present_state #(.ACC_W(4)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
      .win_addr(win_addr), .win_rd(win_rd), .win_wr(win_wr), .win_wdata(win_wdata),
      .ccd1_n_pin(ccd1_n), .ccd2_n_pin(ccd2_n), .cstschg_pin(sts_pin), .ready_irq_pin(rdy_pin),
      .zv_capable_in(zv), .interrog_busy(busy), .interrog_done(done), .id_accepts(acc),
      .id_is_32bit(t32), .id_is_16bit(t16), .id_unrecognised(unr), .bad_supply_req(bad),
      .loss_on_removal(loss), .power_req(preq), .power_on(pon), .win_rdata(win_rdata),
      .win_rvalid(win_rvalid), .retest_req(retest_req), .status_change_pin_level_event(status_change_pin_level_event));
   spss_card_model card (.present(present), .sts_lvl(sts), .rdy_lvl(rdy), .ccd1_n(ccd1_n),
      .ccd2_n(ccd2_n), .cstschg(sts_pin), .ready_irq(rdy_pin));

   // 8 ns period
   always #4 core_clk = ~core_clk;
   // event pulses counted, since they stand one cycle only
   always @(posedge core_clk) begin
      if (status_change_pin_level_event === 1'h1) begin
         ev_cnt <= ev_cnt + 1;
      end
   end

   task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_b(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one window read; answer lands on the same edge that takes the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      win_addr <= a;
      win_rd <= 1'h1;
      @(posedge core_clk);
      win_rd <= 1'h0;
      #1;
      chk_b("rvalid", 1'h1, win_rvalid);
      d = win_rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      win_addr <= a;
      win_wdata <= d;
      win_wr <= 1'h1;
      @(posedge core_clk);
      win_wr <= 1'h0;
      #1;
   endtask
   // interrogation result, valid with a one-cycle done
   task automatic idn(input spss_row_s r);
      @(posedge core_clk);
      {acc, t32, t16, unr, zv, done} <= {r.acc, r.t32, r.t16, r.unr, r.zv, 1'h1};
      @(posedge core_clk);
      done <= 1'h0;
   endtask
   // read the status word at 08h and compare it
   task automatic st(input logic [31:0] e);
      rd(8'h08, rd_w);
      chk_w("status", e, rd_w);
   endtask
   task automatic note(input string s);
      $display("end of test %s", s);
   endtask
   task automatic end_sim;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // watchdog, far beyond the roughly 140 cycles the tests need
   initial begin
      #20000;
      err_count++;
      end_sim();
   end

   initial begin
      tick(8);
      sys_rst <= 1'h0;
      tick(6);
      st(32'h3000_0006);
      rd(8'h0C, rd_w);
      chk_w("force readback", 32'h0000_0000, rd_w);
      wr(8'h08, 32'hFFFF_FFFF);
      st(32'h3000_0006);
      note("reset");
      @(posedge core_clk);
      present <= 1'h1;
      rdy <= 1'h1;
      tick(6);
      for (int i = 0; i < 4; i++) begin
         idn(rows[i]);
         st(rows[i].exp);
      end
      note("rows");
      wr(8'h0C, 32'hC000_6B90);
      chk_b("retest", 1'h1, retest_req);
      st(32'hC000_2BD0);
      note("force");
      @(posedge core_clk);
      {preq, pon} <= 2'h3;
      @(posedge core_clk);
      preq <= 1'h0;
      st(32'hC000_29D8);
      @(posedge core_clk);
      bad <= 1'h1;
      @(posedge core_clk);
      bad <= 1'h0;
      st(32'hC000_2BD8);
      idn('{4'h1, 1'h0, 1'h1, 1'h0, 1'h0, 32'h0});
      st(32'h3000_0658);
      @(posedge core_clk);
      loss <= 1'h1;
      @(posedge core_clk);
      loss <= 1'h0;
      st(32'h3000_0758);
      note("flags");
      base = ev_cnt;
      @(posedge core_clk);
      sts <= 1'h1;
      tick(6);
      st(32'h3000_0759);
      @(posedge core_clk);
      sts <= 1'h0;
      tick(6);
      chk_w("events16", base + 2, ev_cnt);
      wr(8'h0C, 32'h3000_0020);
      st(32'h3000_0068);
      base = ev_cnt;
      @(posedge core_clk);
      sts <= 1'h1;
      tick(6);
      sts <= 1'h0;
      tick(6);
      chk_w("events32", base + 1, ev_cnt);
      wr(8'h0C, 32'h3000_0021);
      chk_b("forced event", 1'h1, status_change_pin_level_event);
      note("status pin");
      @(posedge core_clk);
      busy <= 1'h1;
      present <= 1'h0;
      tick(6);
      st(32'h3000_0028);
      @(posedge core_clk);
      busy <= 1'h0;
      tick(6);
      st(32'h3000_002E);
      note("detect");
      // stalled clock enable ignores a read
      @(posedge core_clk);
      ce <= 1'h0;
      win_rd <= 1'h1;
      @(posedge core_clk);
      win_rd <= 1'h0;
      #1;
      chk_b("rvalid held", 1'h0, win_rvalid);
      @(posedge core_clk);
      ce <= 1'h1;
      sys_rst <= 1'h1;
      tick(8);
      sys_rst <= 1'h0;
      tick(6);
      st(32'h3000_0006);
      note("reset again");
      end_sim();
   end
endmodule
